// ===== logic/pll_cfg_pkg.sv
// ============================================================
// shared constants of the dual synthesizer programming port
package pll_cfg_pkg;
  // serial word layout
  localparam int WORD_W = 23;
  localparam int DEST_LSB = 0;
  localparam int DEST_W = 2;
  localparam int REF_LSB = 2;
  localparam int REF_W = 14;
  localparam int LDS_POS = 16;
  localparam int SWAL_LSB = 2;
  localparam int SWAL_W = 7;
  localparam int MAIN_LSB = 9;
  localparam int MAIN_W = 11;
  localparam int PRESC_POS = 20;
  localparam int CP_POS = 21;
  localparam int TOT_W = 19;

  // load destinations: bit 1 picks the section, bit 0 picks the programmable latch
  typedef enum logic [1:0] {
    DEST_IF_REF = 2'b00,
    DEST_IF_PROG = 2'b01,
    DEST_RF_REF = 2'b10,
    DEST_RF_PROG = 2'b11
  } dest_t;

  // divider limits and values after reset
  localparam logic [REF_W-1:0] REF_MIN = 14'h0003;
  localparam logic [REF_W-1:0] REF_RST = 14'h0003;
  localparam logic [MAIN_W-1:0] MAIN_MIN = 11'h003;
  localparam logic [MAIN_W-1:0] MAIN_RST = 11'h003;
  localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 23'h000000;

  // prescaler modulus as a power-of-two shift
  localparam logic [2:0] IF_SHIFT_LO = 3'h5;
  localparam logic [2:0] IF_SHIFT_HI = 3'h6;
  localparam logic [2:0] RF_SHIFT_LO = 3'h6;
  localparam logic [2:0] RF_SHIFT_HI = 3'h7;

  // lock detector timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOCK_WIN_NS = 200;
  localparam int LOCK_WIN_CYC = (LOCK_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LOCK_WIN_CNT = 3'(LOCK_WIN_CYC);
  localparam logic [2:0] SINCE_MAX = 3'h7;
  localparam logic [1:0] LOCK_GOOD_CNT = 2'h3;

  typedef enum logic {
    LK_HUNT = 1'b0,
    LK_LOCKED = 1'b1
  } lock_t;

  // wishbone register offsets
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADR_W-1:0] OFS_IF_REF = 8'h04;
  localparam logic [ADR_W-1:0] OFS_IF_PROG = 8'h08;
  localparam logic [ADR_W-1:0] OFS_RF_REF = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_RF_PROG = 8'h10;
  localparam logic [ADR_W-1:0] OFS_WORD = 8'h14;

  // status field positions
  localparam int ST_ACT_LSB = 0;
  localparam int ST_LOCK_LSB = 2;
  localparam int ST_PIN_POS = 4;
  localparam int ST_LDS_POS = 5;
endpackage : pll_cfg_pkg

// ===== logic/serial_shift_reg.sv
`timescale 1ns/1ps
// ============================================================
// serial shift register on the link clock
module serial_shift_reg (
  input wire logic serialClk,
  input wire logic rst_n,
  input wire logic serialData,
  output logic [pll_cfg_pkg::WORD_W-1:0] shiftWord
);
  import pll_cfg_pkg::*;

  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;

  // new bit enters at the bottom, oldest bit leaves at the top
  always_comb begin
    shift_nxt = {shift_r[WORD_W-2:0], serialData}; // [RULE_01]
  end

  always_ff @(posedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= WORD_RST;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  assign shiftWord = shift_r;

  // checked from the second link edge on, so the previous edge always has a sample
  a_shift_in: assert property (@(posedge serialClk) disable iff (!rst_n)
    1'b1 |=> shift_r[0] == $past(serialData) && shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]))
    else $error("serial bit not shifted in"); // [RULE_01]
endmodule : serial_shift_reg

// ===== logic/dual_pll_serial_program_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: each rising serial clock edge shifts one data bit into the 23-bit register.
// RULE_02: a high load strobe copies the shifted word into the latch its control bits pick.
// RULE_03: four load targets exist: IF reference, IF programmable, RF reference, RF programmable.
// RULE_04: each reference divider is 14 bits, ratio 3 to 16383.
// RULE_05: the main divider holds a 7-bit swallow count, 0 to 127.
// RULE_06: the main divider holds an 11-bit programmable count, 3 to 2047.
// RULE_07: a word bit picks prescaler 64/65 or 128/129 for RF, 32/33 or 64/65 for IF.
// RULE_08: a word bit picks the charge pump current, 1.5 mA or 6 mA.
// RULE_09: lock output select high shows the phase monitor, low shows lock detect.
// RULE_10: each section runs while its power-save pin is high, sleeps while low.
// RULE_11: the controller holds both power-save pins low at power-up, never floating.
// RULE_12: a digital lock detector reports locked or unlocked on lock detect.
// RULE_13: the controller shifts all 23 bits with strobe low, then pulses strobe once.
module dual_pll_serial_program_port (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic load_latch_strobe,
  input wire logic if_power_save_n,
  input wire logic rf_power_save_n,
  input wire logic ifFeedback,
  input wire logic rfFeedback,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pll_cfg_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic lockMonitorOut,
  output logic ifCpHighSel,
  output logic rfCpHighSel,
  output logic ifPrescHighSel,
  output logic rfPrescHighSel
);
  import pll_cfg_pkg::*;

  // ============================================================
  // link side: shift register on the serial clock
  logic [WORD_W-1:0] shiftWord;

  serial_shift_reg uShift (
    .serialClk(serialClk),
    .rst_n(rst_n),
    .serialData(serialData),
    .shiftWord(shiftWord)
  );

  // ============================================================
  // pin synchronisers
  logic strobeS1_r, strobeS2_r, strobeDly_r;
  logic strobeS1_nxt, strobeS2_nxt, strobeDly_nxt;
  logic [1:0] psS1_r, psS2_r, fbS1_r, fbS2_r, fbDly_r;
  logic [1:0] psS1_nxt, psS2_nxt, fbS1_nxt, fbS2_nxt, fbDly_nxt;
  logic strobeRise;
  logic [1:0] active;
  logic [1:0] fbEdge;

  // two flops per pin, a third on strobe and feedback for edge detect; power-save pins are trusted to be driven low at power-up [RULE_11]
  always_comb begin
    strobeS1_nxt = load_latch_strobe;
    strobeS2_nxt = strobeS1_r;
    strobeDly_nxt = strobeS2_r;
    psS1_nxt = {rf_power_save_n, if_power_save_n};
    psS2_nxt = psS1_r;
    fbS1_nxt = {rfFeedback, ifFeedback};
    fbS2_nxt = fbS1_r;
    fbDly_nxt = fbS2_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strobeS1_r <= 1'b0;
      strobeS2_r <= 1'b0;
      strobeDly_r <= 1'b0;
      psS1_r <= 2'h0;
      psS2_r <= 2'h0;
      fbS1_r <= 2'h0;
      fbS2_r <= 2'h0;
      fbDly_r <= 2'h0;
    end else begin
      strobeS1_r <= strobeS1_nxt;
      strobeS2_r <= strobeS2_nxt;
      strobeDly_r <= strobeDly_nxt;
      psS1_r <= psS1_nxt;
      psS2_r <= psS2_nxt;
      fbS1_r <= fbS1_nxt;
      fbS2_r <= fbS2_nxt;
      fbDly_r <= fbDly_nxt;
    end
  end

  // the word is quiet while the strobe is high, so it is read only at the strobe edge [RULE_13]
  assign strobeRise = strobeS2_r & ~strobeDly_r;
  assign active = psS2_r; // [RULE_10]
  assign fbEdge = fbS2_r & ~fbDly_r;

  // ============================================================
  // wishbone request decode and word merge
  logic wbReq, swLoad;
  logic [WORD_W-1:0] swMerge;
  logic [WORD_W-1:0] swWord_r, swWord_nxt;

  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master sees ack, not one edge before
  assign swLoad = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (wb_adr_i == OFS_WORD);

  // byte lanes not selected keep the last software word
  always_comb begin
    swMerge = swWord_r;
    for (int i = 0; i < WORD_W; i++) begin
      if (wb_sel_i[i / 8]) begin
        swMerge[i] = wb_dat_i[i];
      end
    end
    swWord_nxt = swLoad ? swMerge : swWord_r;
  end

  // ============================================================
  // divider and option latches
  logic [REF_W-1:0] refDiv_r [2];
  logic [REF_W-1:0] refDiv_nxt [2];
  logic [SWAL_W-1:0] swal_r [2];
  logic [SWAL_W-1:0] swal_nxt [2];
  logic [MAIN_W-1:0] main_r [2];
  logic [MAIN_W-1:0] main_nxt [2];
  logic [1:0] presc_r, presc_nxt, cp_r, cp_nxt;
  logic lds_r, lds_nxt;

  // serial load first, a bus load in the same cycle overrides the same latch
  always_comb begin
    logic ld;
    logic [WORD_W-1:0] w;
    logic sec;
    ld = 1'b0;
    w = WORD_RST;
    sec = 1'b0;
    refDiv_nxt = refDiv_r;
    swal_nxt = swal_r;
    main_nxt = main_r;
    presc_nxt = presc_r;
    cp_nxt = cp_r;
    lds_nxt = lds_r;
    for (int s = 0; s < 2; s++) begin
      ld = (s == 0) ? strobeRise : swLoad; // [RULE_02]
      w = (s == 0) ? shiftWord : swMerge;
      sec = w[DEST_LSB + 1];
      if (ld) begin
        // bit 0 of the destination picks reference or programmable latch [RULE_03]
        if (!w[DEST_LSB]) begin
          refDiv_nxt[sec] = w[REF_LSB +: REF_W]; // [RULE_04]
          lds_nxt = w[LDS_POS];
        end else begin
          swal_nxt[sec] = w[SWAL_LSB +: SWAL_W]; // [RULE_05]
          main_nxt[sec] = w[MAIN_LSB +: MAIN_W]; // [RULE_06]
          presc_nxt[sec] = w[PRESC_POS]; // [RULE_07]
          cp_nxt[sec] = w[CP_POS]; // [RULE_08]
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        refDiv_r[i] <= REF_RST;
        swal_r[i] <= SWAL_RST;
        main_r[i] <= MAIN_RST;
      end
      presc_r <= 2'h0;
      cp_r <= 2'h0;
      lds_r <= 1'b0;
      swWord_r <= WORD_RST;
    end else begin
      refDiv_r <= refDiv_nxt;
      swal_r <= swal_nxt;
      main_r <= main_nxt;
      presc_r <= presc_nxt;
      cp_r <= cp_nxt;
      lds_r <= lds_nxt;
      swWord_r <= swWord_nxt;
    end
  end

  // ============================================================
  // per-section dividers and lock detector
  logic [1:0] locked, refTickV;

  for (genvar g = 0; g < 2; g++) begin : gSec
    logic [REF_W-1:0] effRef, refCnt_r, refCnt_nxt;
    logic [MAIN_W-1:0] effMain;
    logic [2:0] pShift, since_r, since_nxt;
    logic [TOT_W-1:0] total, mainCnt_r, mainCnt_nxt;
    logic [1:0] good_r, good_nxt;
    lock_t lk_r, lk_nxt;
    logic refTick, mainTick, inWin;

    // ratios below the minimum run at the minimum
    assign effRef = (refDiv_r[g] < REF_MIN) ? REF_MIN : refDiv_r[g]; // [RULE_04]
    assign effMain = (main_r[g] < MAIN_MIN) ? MAIN_MIN : main_r[g]; // [RULE_06]
    assign pShift = (g == 0) ? (presc_r[g] ? IF_SHIFT_HI : IF_SHIFT_LO)
                             : (presc_r[g] ? RF_SHIFT_HI : RF_SHIFT_LO); // [RULE_07]
    // pulse swallow total: main count times modulus plus swallow count
    assign total = (TOT_W'(effMain) << pShift) + TOT_W'(swal_r[g]); // [RULE_05]
    assign refTick = active[g] && (refCnt_r >= effRef - 14'h0001);
    assign mainTick = active[g] && fbEdge[g] && (mainCnt_r >= total - 19'h00001);
    assign inWin = mainTick || (since_r <= LOCK_WIN_CNT);

    // counters and lock state; a sleeping section is held cleared
    always_comb begin
      refCnt_nxt = refTick ? 14'h0000 : refCnt_r + 14'h0001;
      mainCnt_nxt = mainCnt_r;
      since_nxt = since_r;
      good_nxt = good_r;
      lk_nxt = lk_r;
      if (fbEdge[g]) begin
        mainCnt_nxt = mainTick ? 19'h00000 : mainCnt_r + 19'h00001;
      end
      if (mainTick) begin
        since_nxt = 3'h0;
      end else if (since_r != SINCE_MAX) begin
        since_nxt = since_r + 3'h1;
      end
      if (refTick) begin
        case (lk_r)
          LK_HUNT: begin
            if (inWin) begin
              good_nxt = good_r + 2'h1;
              if (good_r == LOCK_GOOD_CNT - 2'h1) begin
                lk_nxt = LK_LOCKED; // [RULE_12]
              end
            end else begin
              good_nxt = 2'h0;
            end
          end
          LK_LOCKED: begin
            if (!inWin) begin
              lk_nxt = LK_HUNT; // [RULE_12]
              good_nxt = 2'h0;
            end
          end
          default: lk_nxt = LK_HUNT;
        endcase
      end
      if (!active[g]) begin
        refCnt_nxt = 14'h0000; // [RULE_10]
        mainCnt_nxt = 19'h00000;
        since_nxt = SINCE_MAX;
        good_nxt = 2'h0;
        lk_nxt = LK_HUNT;
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        refCnt_r <= 14'h0000;
        mainCnt_r <= 19'h00000;
        since_r <= SINCE_MAX;
        good_r <= 2'h0;
        lk_r <= LK_HUNT;
      end else begin
        refCnt_r <= refCnt_nxt;
        mainCnt_r <= mainCnt_nxt;
        since_r <= since_nxt;
        good_r <= good_nxt;
        lk_r <= lk_nxt;
      end
    end

    assign locked[g] = (lk_r == LK_LOCKED);
    assign refTickV[g] = refTick;

    a_ref_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
      refTick |=> !refTick [*2])
      else $error("reference divider ratio below three"); // [RULE_04]
    a_main_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
      mainTick |=> mainCnt_r == 19'h00000 ##1 mainCnt_r <= 19'h00001)
      else $error("main divider did not wrap"); // [RULE_05] [RULE_06]
    a_sleep_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      !active[g] |=> refCnt_r == 14'h0000 && lk_r == LK_HUNT && mainCnt_r == 19'h00000)
      else $error("sleeping section still counting"); // [RULE_10]
    a_unlock_miss: assert property (@(posedge mclk) disable iff (!rst_n)
      refTick && !inWin |=> good_r == 2'h0 && lk_r == LK_HUNT)
      else $error("missed comparison kept lock"); // [RULE_12]
  end

  // ============================================================
  // shared lock pin and option outputs
  logic lockDetectOut, phaseMonitorOut;
  logic lockPin_r, lockPin_nxt;
  logic [1:0] cpSel_r, cpSel_nxt, prescSel_r, prescSel_nxt;

  assign lockDetectOut = (locked[0] | ~active[0]) & (locked[1] | ~active[1]) & (|active); // [RULE_12]
  assign phaseMonitorOut = active[0] ? refTickV[0] : refTickV[1];

  // pin mux and gated option levels
  always_comb begin
    lockPin_nxt = lds_r ? phaseMonitorOut : lockDetectOut; // [RULE_09]
    cpSel_nxt = cp_r & active; // [RULE_08]
    prescSel_nxt = presc_r & active; // [RULE_07]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lockPin_r <= 1'b0;
      cpSel_r <= 2'h0;
      prescSel_r <= 2'h0;
    end else begin
      lockPin_r <= lockPin_nxt;
      cpSel_r <= cpSel_nxt;
      prescSel_r <= prescSel_nxt;
    end
  end

  assign lockMonitorOut = lockPin_r;
  assign ifCpHighSel = cpSel_r[0];
  assign rfCpHighSel = cpSel_r[1];
  assign ifPrescHighSel = prescSel_r[0];
  assign rfPrescHighSel = prescSel_r[1];

  // ============================================================
  // wishbone read data and acknowledge
  logic [31:0] rdData, dat_r, dat_nxt;
  logic ack_r, ack_nxt;

  // latch readbacks use the serial word layout, destination bits included
  always_comb begin
    rdData = 32'h00000000;
    case (wb_adr_i)
      OFS_STATUS: begin
        rdData[ST_ACT_LSB +: 2] = active;
        rdData[ST_LOCK_LSB +: 2] = locked;
        rdData[ST_PIN_POS] = lockPin_r;
        rdData[ST_LDS_POS] = lds_r;
      end
      OFS_IF_REF, OFS_RF_REF: begin
        rdData[DEST_LSB +: DEST_W] = (wb_adr_i == OFS_IF_REF) ? DEST_IF_REF : DEST_RF_REF;
        rdData[REF_LSB +: REF_W] = refDiv_r[wb_adr_i == OFS_RF_REF];
        rdData[LDS_POS] = lds_r;
      end
      OFS_IF_PROG, OFS_RF_PROG: begin
        rdData[DEST_LSB +: DEST_W] = (wb_adr_i == OFS_IF_PROG) ? DEST_IF_PROG : DEST_RF_PROG;
        rdData[SWAL_LSB +: SWAL_W] = swal_r[wb_adr_i == OFS_RF_PROG];
        rdData[MAIN_LSB +: MAIN_W] = main_r[wb_adr_i == OFS_RF_PROG];
        rdData[PRESC_POS] = presc_r[wb_adr_i == OFS_RF_PROG];
        rdData[CP_POS] = cp_r[wb_adr_i == OFS_RF_PROG];
      end
      OFS_WORD: rdData[WORD_W-1:0] = swWord_r;
      default: rdData = 32'h00000000;
    endcase
    ack_nxt = wbReq;
    dat_nxt = (wbReq & ~wb_we_i) ? rdData : 32'h00000000;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ============================================================
  // checks on loads and outputs
  logic [REF_W-1:0] serRefField;
  assign serRefField = shiftWord[REF_LSB +: REF_W];

  a_load_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    strobeRise && !swLoad && shiftWord[DEST_LSB +: DEST_W] == DEST_IF_REF
    |=> refDiv_r[0] == $past(serRefField))
    else $error("strobe did not load reference latch"); // [RULE_02]
  a_dest_isolate: assert property (@(posedge mclk) disable iff (!rst_n)
    strobeRise && !swLoad && shiftWord[DEST_LSB +: DEST_W] == DEST_IF_REF
    |=> $stable(main_r[0]) && $stable(swal_r[1]) && $stable(refDiv_r[1]))
    else $error("load reached a latch not addressed"); // [RULE_03]
  a_presc_out: assert property (@(posedge mclk) disable iff (!rst_n)
    presc_r[1] && active[1] |=> rfPrescHighSel)
    else $error("prescaler select not shown"); // [RULE_07]
  a_cp_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
    !active[0] |=> !ifCpHighSel)
    else $error("pump current select active while asleep"); // [RULE_08]
  a_lock_mux: assert property (@(posedge mclk) disable iff (!rst_n)
    lds_r && $past(lds_r) |-> lockMonitorOut == $past(phaseMonitorOut))
    else $error("shared pin not showing phase monitor"); // [RULE_09]
  a_wb_ack: assert property (@(posedge mclk) disable iff (!rst_n)
    wbReq |=> wb_ack_o)
    else $error("bus request not acknowledged");
endmodule : dual_pll_serial_program_port

// ===== tb/serial_ctrl_model.sv
`timescale 1ns/1ps
// ============================================================
// three-wire serial controller driving the programming pins
module serial_ctrl_model (
  output logic serialClk,
  output logic serialData,
  output logic load_latch_strobe,
  output logic if_power_save_n,
  output logic rf_power_save_n
);
  // both sections held asleep and every pin driven from power-up
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    load_latch_strobe = 1'b0;
    if_power_save_n = 1'b0;
    rf_power_save_n = 1'b0;
  end

  // shift a whole word msb first with the strobe low, then strobe once
  task automatic send_word(input logic [22:0] w);
    for (int i = 22; i >= 0; i--) begin
      serialData = w[i];
      #3 serialClk = 1'b1;
      #3 serialClk = 1'b0;
    end
    serialData = ~w[0]; // line driven to the inverse of the last bit, stale value not kept
    #20 load_latch_strobe = 1'b1;
    #500 load_latch_strobe = 1'b0; // clock kept still while strobe high
    #400;
  endtask : send_word

  // section run pins, changed as non-blocking updates
  task automatic set_power(input logic ifRun, input logic rfRun);
    if_power_save_n <= ifRun;
    rf_power_save_n <= rfRun;
  endtask : set_power
endmodule : serial_ctrl_model

// ===== tb/dual_pll_serial_program_port_tb.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the programming port
module dual_pll_serial_program_port_tb;
  import pll_cfg_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic serialClk, serialData, strobe, ifRun, rfRun;
  logic ifFb = 1'b0;
  logic rfFb = 1'b0;
  logic fbRun = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [ADR_W-1:0] wbAdr = '0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR, rd;
  logic wbAck, lockMon, ifCp, rfCp, ifPr, rfPr;
  logic [22:0] w [4];
  int n_fail = 0;
  int num_checks = 0;
  int np;

  // ============================================================
  // clock, feedback stimulus and instances
  initial forever #50 mclk = ~mclk;

  // feedback toggles each cycle while enabled
  always @(posedge mclk) begin
    if (fbRun) begin
      ifFb <= ~ifFb;
      rfFb <= ~rfFb;
    end
  end

  serial_ctrl_model u_serial_ctrl_model (
    .serialClk(serialClk), .serialData(serialData), .load_latch_strobe(strobe),
    .if_power_save_n(ifRun), .rf_power_save_n(rfRun)
  );

  dual_pll_serial_program_port u_dual_pll_serial_program_port (
    .mclk(mclk), .rst_n(rst_n), .serialClk(serialClk), .serialData(serialData),
    .load_latch_strobe(strobe), .if_power_save_n(ifRun), .rf_power_save_n(rfRun),
    .ifFeedback(ifFb), .rfFeedback(rfFb), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .lockMonitorOut(lockMon),
    .ifCpHighSel(ifCp), .rfCpHighSel(rfCp), .ifPrescHighSel(ifPr), .rfPrescHighSel(rfPr)
  );

  // ============================================================
  // helpers
  function automatic logic [22:0] ref_word(input logic [13:0] r, input logic s,
                                           input logic [1:0] d);
    return {6'h00, s, r, d};
  endfunction : ref_word

  function automatic logic [22:0] prog_word(input logic cp, input logic pr,
    input logic [10:0] m, input logic [6:0] sw, input logic [1:0] d);
    return {1'b0, cp, pr, m, sw, d};
  endfunction : prog_word

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // one classic cycle: hold until ack is sampled, then release
  task automatic wb_cycle(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hf;
    wbDatW <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      print_verdict();
    end
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge mclk);
  endtask : wb_cycle

  task automatic wb_read(input logic [ADR_W-1:0] a, output logic [31:0] q);
    wb_cycle(1'b0, a, 32'h0, q);
  endtask : wb_read

  task automatic wb_write(input logic [ADR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask : wb_write

  // count cycles with the shared pin high over a window
  task automatic count_pulses(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge mclk);
      if (lockMon === 1'b1) n++;
    end
  endtask : count_pulses

  task automatic settle;
    repeat (8) @(posedge mclk);
  endtask : settle

  // ============================================================
  // watchdog
  initial begin
    #3_000_000;
    n_fail++;
    print_verdict();
  end

  // ============================================================
  // test sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    // reset values of latches and asleep outputs
    wb_read(OFS_IF_REF, rd); check(rd, {9'h0, ref_word(14'h3, 1'b0, DEST_IF_REF)});
    wb_read(OFS_IF_PROG, rd);
    check(rd, {9'h0, prog_word(1'b0, 1'b0, 11'h3, 7'h0, DEST_IF_PROG)});
    wb_read(OFS_STATUS, rd); check(rd[1:0], 32'h0);
    check({ifPr, ifCp, rfPr, rfCp}, 32'h0);
    $display("test reset done");
    // serial load of every destination with boundary values
    w[0] = ref_word(14'h3fff, 1'b1, DEST_IF_REF);
    w[1] = prog_word(1'b1, 1'b1, 11'h7ff, 7'h7f, DEST_IF_PROG);
    // the select bit is shared by both reference latches, so both words carry the same one
    w[2] = ref_word(14'h0003, 1'b1, DEST_RF_REF);
    w[3] = prog_word(1'b0, 1'b1, 11'h003, 7'h00, DEST_RF_PROG);
    for (int i = 0; i < 4; i++) u_serial_ctrl_model.send_word(w[i]);
    settle();
    for (int i = 0; i < 4; i++) begin
      wb_read(ADR_W'(4 * (i + 1)), rd);
      check(rd, {9'h0, w[i]});
    end
    check({ifPr, ifCp, rfPr, rfCp}, 32'h0);
    $display("test serial load done");
    // option outputs follow the latches per section
    u_serial_ctrl_model.set_power(1'b1, 1'b0);
    settle();
    check({ifPr, ifCp, rfPr, rfCp}, 32'hc);
    u_serial_ctrl_model.set_power(1'b1, 1'b1);
    settle();
    check({ifPr, ifCp, rfPr, rfCp}, 32'he);
    wb_read(OFS_STATUS, rd); check(rd[1:0], 32'h3);
    u_serial_ctrl_model.send_word(prog_word(1'b1, 1'b0, 11'h3, 7'h0, DEST_RF_PROG));
    settle();
    check({ifPr, ifCp, rfPr, rfCp}, 32'hd);
    u_serial_ctrl_model.set_power(1'b0, 1'b1);
    settle();
    check({ifPr, ifCp, rfPr, rfCp}, 32'h1);
    $display("test power save done");
    // bus load, read-only write and unmapped read
    u_serial_ctrl_model.set_power(1'b1, 1'b1);
    wb_write(OFS_WORD, {9'h0, ref_word(14'h5, 1'b1, DEST_IF_REF)});
    wb_read(OFS_IF_REF, rd); check(rd, {9'h0, ref_word(14'h5, 1'b1, DEST_IF_REF)});
    wb_write(OFS_IF_REF, 32'hffff_ffff);
    wb_read(OFS_IF_REF, rd); check(rd, {9'h0, ref_word(14'h5, 1'b1, DEST_IF_REF)});
    wb_read(8'h24, rd); check(rd, 32'h0);
    $display("test bus access done");
    // phase monitor on the shared pin at two reference ratios
    fbRun <= 1'b1;
    settle();
    count_pulses(50, np); check(np, 10);
    wb_read(OFS_STATUS, rd); check(rd[5], 32'h1);
    wb_write(OFS_WORD, {9'h0, ref_word(14'h3, 1'b1, DEST_IF_REF)});
    settle();
    count_pulses(30, np); check(np, 10);
    // lock detect shown with feedback stopped: never locked
    fbRun <= 1'b0;
    wb_write(OFS_WORD, {9'h0, ref_word(14'h3, 1'b0, DEST_IF_REF)});
    repeat (20) @(posedge mclk);
    count_pulses(30, np); check(np, 0);
    wb_read(OFS_STATUS, rd); check(rd[5:2], 32'h0);
    $display("test shared pin done");
    // matched periods: ratio 192 against 3 * 32 feedback edges, two cycles each
    u_serial_ctrl_model.set_power(1'b0, 1'b0);
    wb_write(OFS_WORD, {9'h0, prog_word(1'b0, 1'b0, 11'h003, 7'h00, DEST_IF_PROG)});
    wb_write(OFS_WORD, {9'h0, ref_word(14'h00c0, 1'b0, DEST_IF_REF)});
    fbRun <= 1'b1;
    u_serial_ctrl_model.set_power(1'b1, 1'b0);
    repeat (700) @(posedge mclk);
    check(lockMon, 32'h1);
    wb_read(OFS_STATUS, rd); check(rd[5:0], 32'h15);
    // feedback stopped: the next missed comparison drops lock
    fbRun <= 1'b0;
    repeat (450) @(posedge mclk);
    check(lockMon, 32'h0);
    $display("test lock detect done");
    print_verdict();
  end
endmodule : dual_pll_serial_program_port_tb
